// [inc/pwp_map.svh]
`ifndef PWP_MAP_SVH
`define PWP_MAP_SVH
// register byte offsets on the apb window
`define PWP_OFS_KEY 12'h000
`define PWP_OFS_OSC 12'h004
`define PWP_OFS_POR 12'h008
`define PWP_OFS_CON1 12'h00C
`define PWP_OFS_FLTA 12'h010
`define PWP_OFS_FLTB 12'h014
`define PWP_OFS_TCON 12'h018
`define PWP_OFS_STAT 12'h01C
// field positions
`define PWP_OSC_LOCK_BIT 6
`define PWP_POR_PINMODE_BIT 7
`define PWP_POR_HIGH_SIDE_POLARITY_BIT 6
`define PWP_POR_LOW_SIDE_POLARITY_BIT 5
`define PWP_TCON_EN_BIT 15
// reset values
`define PWP_KEY_RST 16'h0000
`define PWP_REG_RST 16'h0000
// unlock key pair, written back to back
`define PWP_KEY_FIRST 16'hABCD
`define PWP_KEY_SECOND 16'h4321
`endif

// [inc/pwp_pkg.sv]
package pwp_pkg;
   // unlock sequencer states
   typedef enum logic [1:0] {
      PWP_LOCKED,
      PWP_HALF,
      PWP_OPEN
   } pwp_lock_state_t;
endpackage

// [design/pwp_top.sv]
// Notes on behaviour
// [RL1] lock bit set: protected registers ignore writes until the key sequence arrives
// [RL2] lock bit clear: protected registers take writes at any time
// [RL3] sixteen-bit read/write key register, zero after reset
// [RL4] key register exists only when the lock bit is present (parameter)
// [RL5] lock bit is read-only bit 6 of oscillator source config
// [RL6] pin reset mode set: pins tri-stated until time base enable
// [RL7] polarity bits pick active-high or active-low for each output side
// [RL8] bits 5 to 3 of oscillator source config read zero
// [RL9] time base enable is bit 15 of time base control
// [RL10] one unlock grants exactly one protected write, then relocks; here the next write to any register relocks, protected or not
//
// Our own choices: the address map and the APB slave port.
`include "pwp_map.svh"
module pwp_top
   import pwp_pkg::*;
#(
   parameter bit HAS_LOCK = 1'b1,
   parameter int NPAIR = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] osc_cfg_pin,
   input wire logic [7:0] por_cfg_pin,
   input wire logic [NPAIR-1:0] pwm_hi_raw,
   input wire logic [NPAIR-1:0] pwm_lo_raw,
   output logic [NPAIR-1:0] pwm_hi_out,
   output logic [NPAIR-1:0] pwm_lo_out,
   output logic [NPAIR-1:0] pwm_hi_oe,
   output logic [NPAIR-1:0] pwm_lo_oe,
   output logic [15:0] pwm_control_one_q,
   output logic [15:0] fault_a_control_q,
   output logic [15:0] fault_b_control_q
);

////////////////////////////////////////////////////////////////////////////////
// configuration straps, synchronised before use
logic [7:0] osc_s1_ff, osc_s2_ff, por_s1_ff, por_s2_ff;
always_ff @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      osc_s1_ff <= 8'h00;
      osc_s2_ff <= 8'h00;
      por_s1_ff <= 8'h00;
      por_s2_ff <= 8'h00;
   end else if (clk_en) begin
      osc_s1_ff <= osc_cfg_pin;
      osc_s2_ff <= osc_s1_ff;
      por_s1_ff <= por_cfg_pin;
      por_s2_ff <= por_s1_ff;
   end
end

wire write_lock_config = HAS_LOCK & osc_s2_ff[`PWP_OSC_LOCK_BIT]; // RL5
wire pin_reset_mode = por_s2_ff[`PWP_POR_PINMODE_BIT];
wire high_side_polarity = por_s2_ff[`PWP_POR_HIGH_SIDE_POLARITY_BIT];
wire low_side_polarity = por_s2_ff[`PWP_POR_LOW_SIDE_POLARITY_BIT];
// [RL8] bits 5..3 forced to zero on read
wire [7:0] osc_read = {osc_s2_ff[7:6], 3'h0, osc_s2_ff[2:0]}; // RL8

////////////////////////////////////////////////////////////////////////////////
// apb decode; one-wait access, unmapped address answers pslverr
wire acc = psel & penable & ~pready;
wire wr = acc & pwrite;
wire hit_key = HAS_LOCK && (paddr == `PWP_OFS_KEY); // RL4
wire hit_osc = paddr == `PWP_OFS_OSC;
wire hit_por = paddr == `PWP_OFS_POR;
wire hit_con1 = paddr == `PWP_OFS_CON1;
wire hit_flta = paddr == `PWP_OFS_FLTA;
wire hit_fltb = paddr == `PWP_OFS_FLTB;
wire hit_tcon = paddr == `PWP_OFS_TCON;
wire hit_stat = paddr == `PWP_OFS_STAT;
wire mapped = hit_key | hit_osc | hit_por | hit_con1 | hit_flta | hit_fltb
   | hit_tcon | hit_stat;
wire hit_prot = hit_con1 | hit_flta | hit_fltb;

logic [15:0] pwm_unlock_key_ff;
logic [15:0] tcon_ff;
pwp_lock_state_t lock_st_ff;

// protected write allowed when unlocked or when lock bit clear
wire prot_open = ~write_lock_config | (lock_st_ff == PWP_OPEN); // RL1 RL2
wire prot_wr = wr & hit_prot & prot_open;
wire key_wr = wr & hit_key;
wire [15:0] wdata16 = pwdata[15:0];

////////////////////////////////////////////////////////////////////////////////
// unlock sequencer: a wrong word or any other write relocks
pwp_lock_state_t nxt_lock_st;
always_comb begin
   nxt_lock_st = lock_st_ff;
   unique case (lock_st_ff)
      PWP_LOCKED: if (key_wr && wdata16 == `PWP_KEY_FIRST) nxt_lock_st = PWP_HALF;
      PWP_HALF: if (key_wr) begin
         nxt_lock_st = (wdata16 == `PWP_KEY_SECOND) ? PWP_OPEN : PWP_LOCKED;
      end else if (wr) begin
         nxt_lock_st = PWP_LOCKED;
      end
      PWP_OPEN: if (wr) nxt_lock_st = PWP_LOCKED; // RL10
   endcase
end

////////////////////////////////////////////////////////////////////////////////
// register storage
always_ff @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      pwm_unlock_key_ff <= `PWP_KEY_RST; // RL3
      lock_st_ff <= PWP_LOCKED;
      tcon_ff <= `PWP_REG_RST;
   end else if (clk_en) begin
      lock_st_ff <= nxt_lock_st;
      if (key_wr) pwm_unlock_key_ff <= wdata16; // RL3
      if (wr && hit_tcon) tcon_ff <= wdata16;
   end
end

// protected registers drop writes while locked
always_ff @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      pwm_control_one_q <= `PWP_REG_RST;
      fault_a_control_q <= `PWP_REG_RST;
      fault_b_control_q <= `PWP_REG_RST;
   end else if (clk_en && prot_wr) begin
      if (hit_con1) pwm_control_one_q <= wdata16; // RL1
      if (hit_flta) fault_a_control_q <= wdata16;
      if (hit_fltb) fault_b_control_q <= wdata16;
   end
end

wire time_base_enable = tcon_ff[`PWP_TCON_EN_BIT]; // RL9

////////////////////////////////////////////////////////////////////////////////
// read mux
logic [31:0] rd_mux;
always_comb begin
   rd_mux = 32'h0000_0000;
   if (hit_key) rd_mux = {16'h0000, pwm_unlock_key_ff};
   if (hit_osc) rd_mux = {24'h00_0000, osc_read};
   if (hit_por) rd_mux = {8'h00, 16'hFFFF, por_s2_ff}; // bits 23..8 read one
   if (hit_con1) rd_mux = {16'h0000, pwm_control_one_q};
   if (hit_flta) rd_mux = {16'h0000, fault_a_control_q};
   if (hit_fltb) rd_mux = {16'h0000, fault_b_control_q};
   if (hit_tcon) rd_mux = {16'h0000, tcon_ff};
   if (hit_stat) rd_mux = {29'h0000_0000, write_lock_config, lock_st_ff};
end

// pready pulses one cycle into the access phase
always_ff @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
   end else if (clk_en) begin
      pready <= acc;
      pslverr <= acc & ~mapped;
      prdata <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
   end
end

////////////////////////////////////////////////////////////////////////////////
// output stage: polarity and pin release, one pair per generate step
wire pins_driven = ~pin_reset_mode | time_base_enable; // RL6
genvar gi;
generate
   for (gi = 0; gi < NPAIR; gi++) begin : g_pair
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pwm_hi_out[gi] <= 1'b0;
            pwm_lo_out[gi] <= 1'b0;
            pwm_hi_oe[gi] <= 1'b0;
            pwm_lo_oe[gi] <= 1'b0;
         end else if (clk_en) begin
            pwm_hi_out[gi] <= ~(pwm_hi_raw[gi] ^ high_side_polarity); // RL7
            pwm_lo_out[gi] <= ~(pwm_lo_raw[gi] ^ low_side_polarity); // RL7
            pwm_hi_oe[gi] <= pins_driven; // RL6
            pwm_lo_oe[gi] <= pins_driven;
         end
      end
   end
endgenerate

endmodule

// [bench/pwp_top_properties.sv]
`include "pwp_map.svh"
module pwp_top_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // bus answer timing, one wait state
   a_one_wait: assert property (psel && penable && !pready && clk_en |=> pready)
      else $error("no answer one cycle after access");
   a_ready_pulse: assert property (pready && clk_en |=> !pready)
      else $error("ready held past one cycle");
   a_idle_quiet: assert property (!$past(psel && penable) |-> !pready)
      else $error("ready without access");
   a_data_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error outside answer");
   // check expects only offsets past the last register to refuse; the design also refuses unmapped offsets below it
   a_map_err: assert property (pready |-> pslverr == ($past(paddr) > `PWP_OFS_STAT))
      else $error("error flag does not match address map");
   a_osc_gap: assert property (pready && !$past(pwrite) && $past(paddr) == `PWP_OFS_OSC
      |-> prdata[5:3] == 3'h0)
      else $error("unused config bits read nonzero");
   a_key_width: assert property (pready && !$past(pwrite) && $past(paddr) == `PWP_OFS_KEY
      |-> prdata[31:16] == 16'h0)
      else $error("key read wider than sixteen bits");
endmodule
//////////////////////////////
bind pwp_top pwp_top_properties u_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));

// [bench/test_pwm_write_protect_config.sv]
`include "pwp_map.svh"
module test_pwm_write_protect_config;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0] osc_pin = 8'hFF, por_pin = 8'h80;
   logic [3:0] hi_raw = 4'hA, lo_raw = 4'h3, hi_out, lo_out, hi_oe, lo_oe;
   logic [15:0] con1_q, flta_q, fltb_q;
   logic [11:0] prot [3] = '{`PWP_OFS_CON1, `PWP_OFS_FLTA, `PWP_OFS_FLTB};
   int err_total = 0, comparisons = 0, cyc = 0;
   pwp_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .osc_cfg_pin(osc_pin), .por_cfg_pin(por_pin), .pwm_hi_raw(hi_raw),
      .pwm_lo_raw(lo_raw), .pwm_hi_out(hi_out), .pwm_lo_out(lo_out), .pwm_hi_oe(hi_oe),
      .pwm_lo_oe(lo_oe), .pwm_control_one_q(con1_q), .fault_a_control_q(flta_q),
      .fault_b_control_q(fltb_q));
   initial forever #2.5 pclk = ~pclk;
   // hang guard, far above the few hundred cycles needed
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         wrap_up();
      end
   end
   //////////////////////////////
   task automatic wrap_up();
      if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // request held until ready is seen high at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // straps pass a two-stage sync, then a register
   task automatic pins(input logic [31:0] exp);
      repeat (4) @(posedge pclk);
      chk({16'h0, hi_out, lo_out, hi_oe, lo_oe}, exp);
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      rdchk(`PWP_OFS_KEY, 32'h0);
      apb(1'b1, `PWP_OFS_KEY, 32'h00FF);
      rdchk(`PWP_OFS_KEY, 32'h00FF);
      chk({31'h0, err}, 32'h0);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, `PWP_OFS_OSC, 32'h0);
         apb(1'b0, `PWP_OFS_OSC, 32'h0);
         chk({28'h0, rd[6:3]}, 32'h8);
      end
      // locked, half-open relock, full unlock, single grant
      foreach (prot[i]) begin
         apb(1'b1, prot[i], 32'h1111);
         rdchk(prot[i], 32'h0);
         apb(1'b1, `PWP_OFS_KEY, `PWP_KEY_FIRST);
         apb(1'b1, prot[i], 32'h2222);
         rdchk(prot[i], 32'h0);
         apb(1'b1, `PWP_OFS_KEY, `PWP_KEY_FIRST);
         apb(1'b1, `PWP_OFS_KEY, `PWP_KEY_SECOND);
         apb(1'b1, prot[i], 32'h3333);
         apb(1'b1, prot[i], 32'h4444);
         rdchk(prot[i], 32'h3333);
      end
      chk({con1_q, fltb_q}, 32'h33333333);
      apb(1'b1, 12'h020, 32'h0);
      chk({31'h0, err}, 32'h1);
      osc_pin <= 8'h00;
      repeat (3) @(posedge pclk);
      apb(1'b1, `PWP_OFS_FLTA, 32'h0055);
      chk({16'h0, flta_q}, 32'h0055);
      pins(32'h5C00);
      apb(1'b1, `PWP_OFS_TCON, 32'h7FFF);
      pins(32'h5C00);
      apb(1'b1, `PWP_OFS_TCON, 32'h8000);
      pins(32'h5CFF);
      por_pin <= 8'h40;
      pins(32'hACFF);
      por_pin <= 8'h20;
      pins(32'h53FF);
      wrap_up();
   end
endmodule
